// [hw/usb_hub_config_bypass.sv]
`timescale 1ns/1ps
// Summary of operation
// - Thirteen byte hub registers in MCU space
// - Held hub ignores all host requests
// - Released hub accepts upstream host packets
// - Ports disabled until host enables them
// - No loop select set: native mode
// - Port 2 select: port 1 to 2
// - Port 3 select: port 1 to 3
// - Port 4 select: port 1 to 4
// - Port 5 select: port 1 to 5
// - Source flags clear on written one only
module usb_hub_config_bypass
   import hub_cfg_pkg::*;
#(
   parameter int unsigned INIT_WINDOW_CYCLES = INIT_WINDOW_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // MCU memory port
   input wire logic [3:0] mcu_addr,
   input wire logic mcu_wr,
   input wire logic mcu_rd,
   input wire logic [7:0] mcu_wdata,
   output logic [7:0] mcu_rdata,
   // Upstream host requests
   input wire logic host_req_valid,
   output logic host_req_taken,
   // Host port control packets, bit n-1 is port n
   input wire logic [4:0] port_enable_cmd,
   input wire logic [4:0] port_disable_cmd,
   output logic [4:0] port_enabled,
   // Event sources
   input wire logic [7:0] int_event_one,
   input wire logic [7:0] int_event_two,
   input wire logic [7:0] wake_event_one,
   input wire logic [7:0] wake_event_two,
   // Configuration outputs
   output ident_t ident,
   output route_t route,
   output logic init_window_open
);

   // Window counter is 16 bits wide; refuse lengths it cannot hold
   if (INIT_WINDOW_CYCLES < 1 || INIT_WINDOW_CYCLES > 65535) begin : g_bad_window
      $error("INIT_WINDOW_CYCLES out of range");
   end

   // -----------------------------
   // Helpers
   // -----------------------------
   // Set wins over clear; a read never touches the flags
   function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] ev,
                                      input logic hit, input logic [7:0] data);
      logic [7:0] clr;
      clr = hit ? data : 8'h00;
      return (cur & ~clr) | ev;
   endfunction : w1c

   // -----------------------------
   // Register file
   // -----------------------------
   ident_t ident_q, ident_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] reserved_q, reserved_d;
   logic [7:0] int_one_q, int_one_d;
   logic [7:0] int_two_q, int_two_d;
   logic [7:0] wake_one_q, wake_one_d;
   logic [7:0] wake_two_q, wake_two_d;
   logic [7:0] rdata_q, rdata_d;
   logic [7:0] status_byte;
   hub_state_t state_q, state_d;
   logic [15:0] win_q, win_d;
   logic [4:0] en_q, en_d;
   logic run;

   always_comb begin
      ident_d = ident_q;
      ctrl_d = ctrl_q;
      reserved_d = reserved_q;
      if (mcu_wr) begin
         if (mcu_addr == VENDOR_ID_LOW_IDX) begin
            ident_d.vendor_low = mcu_wdata;
         end else if (mcu_addr == VENDOR_ID_HIGH_IDX) begin
            ident_d.vendor_high = mcu_wdata;
         end else if (mcu_addr == PRODUCT_ID_LOW_IDX) begin
            ident_d.product_low = mcu_wdata;
         end else if (mcu_addr == PRODUCT_ID_HIGH_IDX) begin
            ident_d.product_high = mcu_wdata;
         end else if (mcu_addr == RELEASE_NUMBER_LOW_IDX) begin
            ident_d.release_low = mcu_wdata;
         end else if (mcu_addr == RELEASE_NUMBER_HIGH_IDX) begin
            ident_d.release_high = mcu_wdata;
         end else if (mcu_addr == HUB_CONTROL_ONE_IDX) begin
            ctrl_d = mcu_wdata;
         end else if (mcu_addr == HUB_RESERVED_IDX) begin
            reserved_d = mcu_wdata;
         end
      end
      int_one_d = w1c(int_one_q, int_event_one, mcu_wr && mcu_addr == INT_SOURCE_ONE_IDX,
                      mcu_wdata);
      int_two_d = w1c(int_two_q, int_event_two, mcu_wr && mcu_addr == INT_SOURCE_TWO_IDX,
                      mcu_wdata);
      wake_one_d = w1c(wake_one_q, wake_event_one,
                       mcu_wr && mcu_addr == WAKE_SOURCE_ONE_IDX, mcu_wdata);
      wake_two_d = w1c(wake_two_q, wake_event_two,
                       mcu_wr && mcu_addr == WAKE_SOURCE_TWO_IDX, mcu_wdata);
   end

   // Read data: one cycle after the read strobe, held until the next read
   assign status_byte = {5'h00, init_window_open, run, |en_q};

   always_comb begin
      rdata_d = rdata_q;
      if (mcu_rd) begin
         if (mcu_addr == VENDOR_ID_LOW_IDX) begin
            rdata_d = ident_q.vendor_low;
         end else if (mcu_addr == VENDOR_ID_HIGH_IDX) begin
            rdata_d = ident_q.vendor_high;
         end else if (mcu_addr == PRODUCT_ID_LOW_IDX) begin
            rdata_d = ident_q.product_low;
         end else if (mcu_addr == PRODUCT_ID_HIGH_IDX) begin
            rdata_d = ident_q.product_high;
         end else if (mcu_addr == RELEASE_NUMBER_LOW_IDX) begin
            rdata_d = ident_q.release_low;
         end else if (mcu_addr == RELEASE_NUMBER_HIGH_IDX) begin
            rdata_d = ident_q.release_high;
         end else if (mcu_addr == HUB_CONTROL_ONE_IDX) begin
            rdata_d = ctrl_q;
         end else if (mcu_addr == HUB_RESERVED_IDX) begin
            rdata_d = reserved_q;
         end else if (mcu_addr == INT_SOURCE_ONE_IDX) begin
            rdata_d = int_one_q;
         end else if (mcu_addr == INT_SOURCE_TWO_IDX) begin
            rdata_d = int_two_q;
         end else if (mcu_addr == WAKE_SOURCE_ONE_IDX) begin
            rdata_d = wake_one_q;
         end else if (mcu_addr == WAKE_SOURCE_TWO_IDX) begin
            rdata_d = wake_two_q;
         end else if (mcu_addr == HUB_STATUS_IDX) begin
            rdata_d = status_byte;
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ident_q <= '0;
         ctrl_q <= HUB_CONTROL_RESET;
         reserved_q <= BYTE_RESET;
         int_one_q <= BYTE_RESET;
         int_two_q <= BYTE_RESET;
         wake_one_q <= BYTE_RESET;
         wake_two_q <= BYTE_RESET;
         rdata_q <= BYTE_RESET;
      end else begin
         ident_q <= ident_d;
         ctrl_q <= ctrl_d;
         reserved_q <= reserved_d;
         int_one_q <= int_one_d;
         int_two_q <= int_two_d;
         wake_one_q <= wake_one_d;
         wake_two_q <= wake_two_d;
         rdata_q <= rdata_d;
      end
   end

   // -----------------------------
   // Hub run state and ports
   // -----------------------------
   assign run = ctrl_q[RUN_RELEASE_BIT];

   // Window only reports the setup time; the hub does not enforce it
   always_comb begin
      state_d = state_q;
      win_d = win_q;
      case (state_q)
         HUB_HELD: begin
            if (run) begin
               state_d = HUB_INIT_WINDOW;
               win_d = 16'(INIT_WINDOW_CYCLES);
            end
         end
         HUB_INIT_WINDOW: begin
            win_d = win_q - 16'h0001;
            if (!run) begin
               state_d = HUB_HELD;
            end else if (win_q == 16'h0001) begin
               state_d = HUB_RUNNING;
            end
         end
         default: begin
            if (!run) begin
               state_d = HUB_HELD;
            end
         end
      endcase
      // Ports come up disabled; only a host control packet enables one
      en_d = (en_q | port_enable_cmd) & ~port_disable_cmd & route.hub_ports;
      if (!run) begin
         en_d = 5'h00;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_q <= HUB_HELD;
         win_q <= 16'h0000;
         en_q <= 5'h00;
      end else begin
         state_q <= state_d;
         win_q <= win_d;
         en_q <= en_d;
      end
   end

   port_route u_route (
      .loop_select(ctrl_q[LOOP_SELECT_LSB +: LOOP_SELECT_W]),
      .route(route)
   );

   assign host_req_taken = host_req_valid && run;
   assign port_enabled = en_q;
   assign mcu_rdata = rdata_q;
   assign ident = ident_q;
   assign init_window_open = (state_q == HUB_INIT_WINDOW);

   // -----------------------------
   // Checks
   // -----------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   held_ignores_a: assert property (!run |-> !host_req_taken)
      else $error("Host request taken while hub held");
   run_accepts_a: assert property (run && host_req_valid |-> host_req_taken)
      else $error("Host request dropped while hub running");
   ports_start_off_a: assert property ($rose(run) |-> port_enabled == 5'h00)
      else $error("Port enabled at hub release");
   native_mode_a: assert property (ctrl_q[4:1] == 4'h0 |->
      route.hub_ports == ALL_PORTS && route.p1_upstream == 3'h0)
      else $error("Native mode routing wrong");
   loop_two_a: assert property (ctrl_q[1] |-> route.p1_upstream == 3'h2
      && !route.hub_ports[0] && !route.hub_ports[1])
      else $error("Port 2 loop routing wrong");
   loop_three_a: assert property (ctrl_q[2:1] == 2'b10 |-> route.p1_upstream == 3'h3
      && route.hub_ports == 5'h1A)
      else $error("Port 3 loop routing wrong");
   loop_four_a: assert property (ctrl_q[3:1] == 3'b100 |-> route.p1_upstream == 3'h4
      && route.hub_ports == 5'h16)
      else $error("Port 4 loop routing wrong");
   loop_five_a: assert property (ctrl_q[4:1] == 4'b1000 |-> route.p1_upstream == 3'h5
      && route.hub_ports == 5'h0E)
      else $error("Port 5 loop routing wrong");
   flag_read_keeps_a: assert property (!mcu_wr |=>
      (int_one_q & $past(int_one_q)) == $past(int_one_q))
      else $error("Source flag cleared without a write");
   flag_w1c_a: assert property (mcu_wr && mcu_addr == INT_SOURCE_ONE_IDX |=>
      int_one_q == (($past(int_one_q) & ~$past(mcu_wdata)) | $past(int_event_one)))
      else $error("Source flag write-one-clear wrong");
   vendor_write_a: assert property (mcu_wr && mcu_addr == VENDOR_ID_LOW_IDX |=>
      ident.vendor_low == $past(mcu_wdata))
      else $error("Vendor low byte not stored");
   window_len_a: assert property ($rose(run) |=> init_window_open [*3])
      else $error("Setup window closed early");

endmodule : usb_hub_config_bypass

// [hw/hub_cfg_pkg.sv]
package hub_cfg_pkg;

   // ----------------------------------------
   // Register indices on the MCU byte map
   // ----------------------------------------
   localparam logic [3:0] VENDOR_ID_LOW_IDX = 4'h0;
   localparam logic [3:0] VENDOR_ID_HIGH_IDX = 4'h1;
   localparam logic [3:0] PRODUCT_ID_LOW_IDX = 4'h2;
   localparam logic [3:0] PRODUCT_ID_HIGH_IDX = 4'h3;
   localparam logic [3:0] RELEASE_NUMBER_LOW_IDX = 4'h4;
   localparam logic [3:0] RELEASE_NUMBER_HIGH_IDX = 4'h5;
   localparam logic [3:0] HUB_CONTROL_ONE_IDX = 4'h6;
   localparam logic [3:0] HUB_RESERVED_IDX = 4'h7;
   localparam logic [3:0] INT_SOURCE_ONE_IDX = 4'h8;
   localparam logic [3:0] INT_SOURCE_TWO_IDX = 4'h9;
   localparam logic [3:0] WAKE_SOURCE_ONE_IDX = 4'hA;
   localparam logic [3:0] WAKE_SOURCE_TWO_IDX = 4'hB;
   localparam logic [3:0] HUB_STATUS_IDX = 4'hC;

   // ----------------------------------------
   // Hub control one fields and reset values
   // ----------------------------------------
   localparam int RUN_RELEASE_BIT = 0;
   localparam int LOOP_SELECT_LSB = 1;
   localparam int LOOP_SELECT_W = 4;
   localparam logic [7:0] HUB_CONTROL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [4:0] ALL_PORTS = 5'h1F;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int INIT_WINDOW_MS = 2;
   localparam int INIT_WINDOW_CYC = (INIT_WINDOW_MS * 1000000) / CLK_PERIOD_NS;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {HUB_HELD, HUB_INIT_WINDOW, HUB_RUNNING} hub_state_t;

   typedef struct packed {
      logic [4:0] hub_ports;   // Bit n-1: port n attached to the hub
      logic [2:0] p1_upstream; // 0: hub, else number of the port feeding port 1
   } route_t;

   typedef struct packed {
      logic [7:0] vendor_low;
      logic [7:0] vendor_high;
      logic [7:0] product_low;
      logic [7:0] product_high;
      logic [7:0] release_low;
      logic [7:0] release_high;
   } ident_t;

endpackage : hub_cfg_pkg

// [hw/port_route.sv]
`timescale 1ns/1ps
module port_route
   import hub_cfg_pkg::*;
(
   // Loop selects, bit 0 is port 2
   input wire logic [3:0] loop_select,
   // Resulting port routing
   output route_t route
);

   // -----------------------------
   // Routing decode
   // -----------------------------
   // Several selects set: the lowest port wins, so the result stays one path
   always_comb begin
      route.hub_ports = ALL_PORTS;
      route.p1_upstream = 3'h0;
      if (loop_select[0]) begin
         route.hub_ports = ALL_PORTS & ~5'h03;
         route.p1_upstream = 3'h2;
      end else if (loop_select[1]) begin
         route.hub_ports = ALL_PORTS & ~5'h05;
         route.p1_upstream = 3'h3;
      end else if (loop_select[2]) begin
         route.hub_ports = ALL_PORTS & ~5'h09;
         route.p1_upstream = 3'h4;
      end else if (loop_select[3]) begin
         route.hub_ports = ALL_PORTS & ~5'h11;
         route.p1_upstream = 3'h5;
      end
   end

endmodule : port_route

// [dv/hub_host_model.sv]
`timescale 1ns/1ps
module hub_host_model (
   // Clock
   input wire logic sys_clk,
   // Hub request handshake
   input wire logic host_req_taken,
   output logic host_req_valid,
   // Port control packets, bit n-1 is port n
   output logic [4:0] port_enable_cmd,
   output logic [4:0] port_disable_cmd
);
   // ----------------------------------------
   // Idle levels
   // ----------------------------------------
   initial begin
      host_req_valid = 1'b0;
      port_enable_cmd = 5'h00;
      port_disable_cmd = 5'h00;
   end

   // ----------------------------------------
   // Host actions
   // ----------------------------------------
   // Request held for hold cycles, so slow hosts are covered too
   task automatic request(input int hold, output logic taken);
      @(negedge sys_clk);
      host_req_valid = 1'b1;
      repeat (hold) @(posedge sys_clk);
      // Answer is combinational; look once it has settled
      @(negedge sys_clk);
      taken = host_req_taken;
      host_req_valid = 1'b0;
   endtask : request

   // One-cycle control packet to the port logic
   task automatic port_cmd(input logic [4:0] en, input logic [4:0] dis);
      @(negedge sys_clk);
      port_enable_cmd = en;
      port_disable_cmd = dis;
      @(negedge sys_clk);
      port_enable_cmd = 5'h00;
      port_disable_cmd = 5'h00;
   endtask : port_cmd
endmodule : hub_host_model

// [dv/usb_hub_config_bypass_tb.sv]
`timescale 1ns/1ps
module usb_hub_config_bypass_tb import hub_cfg_pkg::*;;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   localparam int WIN = 8;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] mcu_addr = 4'h0;
   logic mcu_wr = 1'b0;
   logic mcu_rd = 1'b0;
   logic [7:0] mcu_wdata = 8'h00;
   logic [7:0] mcu_rdata;
   logic [7:0] ev [4] = '{default: 8'h00};
   logic host_req_valid;
   logic host_req_taken;
   logic init_window_open;
   logic [4:0] port_enable_cmd;
   logic [4:0] port_disable_cmd;
   logic [4:0] port_enabled;
   ident_t ident;
   route_t route;
   int miscompares = 0;
   int total_checks = 0;
   logic [7:0] rv;
   logic t;

   always #25 sys_clk = ~sys_clk;

   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   usb_hub_config_bypass #(.INIT_WINDOW_CYCLES(WIN)) uut (
      .sys_clk(sys_clk), .rstn(rstn), .mcu_addr(mcu_addr), .mcu_wr(mcu_wr),
      .mcu_rd(mcu_rd), .mcu_wdata(mcu_wdata), .mcu_rdata(mcu_rdata),
      .host_req_valid(host_req_valid), .host_req_taken(host_req_taken),
      .port_enable_cmd(port_enable_cmd), .port_disable_cmd(port_disable_cmd),
      .port_enabled(port_enabled), .int_event_one(ev[0]), .int_event_two(ev[1]),
      .wake_event_one(ev[2]), .wake_event_two(ev[3]), .ident(ident), .route(route),
      .init_window_open(init_window_open));

   hub_host_model host (
      .sys_clk(sys_clk), .host_req_taken(host_req_taken), .host_req_valid(host_req_valid),
      .port_enable_cmd(port_enable_cmd), .port_disable_cmd(port_disable_cmd));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      mcu_addr = a;
      mcu_wdata = d;
      mcu_wr = 1'b1;
      @(negedge sys_clk);
      mcu_wr = 1'b0;
   endtask : wr

   // Read data is registered, so it is looked at one cycle on
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      mcu_addr = a;
      mcu_rd = 1'b1;
      @(negedge sys_clk);
      mcu_rd = 1'b0;
      d = mcu_rdata;
   endtask : rd

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      for (int a = 0; a < 13; a++) begin
         rd(4'(a), rv);
         check(48'(rv), 48'h0);
      end
      check(48'(route), 48'({5'h1F, 3'h0}));
      host.request(1, t);
      check(48'(t), 48'h0);
      host.port_cmd(5'h1F, 5'h00);
      check(48'(port_enabled), 48'h0);
      // Identity loaded while held, product included
      for (int a = 0; a < 6; a++) wr(4'(a), 8'(8'h11 * (a + 1)));
      wr(4'h7, 8'h5A);
      wr(4'hD, 8'hFF);
      for (int a = 0; a < 6; a++) begin
         rd(4'(a), rv);
         check(48'(rv), 48'(8'(8'h11 * (a + 1))));
      end
      rd(4'h7, rv);
      check(48'(rv), 48'h5A);
      rd(4'hD, rv);
      check(48'(rv), 48'h0);
      check(48'(ident), 48'h112233445566);
      wr(4'h6, 8'h01);
      // Window state follows the run bit by one cycle
      @(negedge sys_clk);
      check(48'(init_window_open), 48'h1);
      host.request(3, t);
      check(48'(t), 48'h1);
      check(48'(port_enabled), 48'h0);
      host.port_cmd(5'h05, 5'h00);
      check(48'(port_enabled), 48'h05);
      host.port_cmd(5'h0A, 5'h09);
      check(48'(port_enabled), 48'h06);
      repeat (WIN) @(negedge sys_clk);
      check(48'(init_window_open), 48'h0);
      rd(4'hC, rv);
      check(48'(rv), 48'h03);
      // One loop select at a time
      for (int p = 2; p < 6; p++) begin
         wr(4'h6, 8'h01 | (8'h01 << (p - 1)));
         check(48'(route), 48'({5'h1F & ~(5'h01 | (5'h01 << (p - 1))), 3'(p)}));
         if (p == 4) begin
            host.port_cmd(5'h0F, 5'h00);
            check(48'(port_enabled), 48'h06);
         end
      end
      wr(4'h6, 8'h01);
      check(48'(route), 48'({5'h1F, 3'h0}));
      // Flags survive reads and clear bit by bit
      for (int i = 0; i < 4; i++) begin
         @(negedge sys_clk);
         ev[i] = 8'hA5;
         @(negedge sys_clk);
         ev[i] = 8'h00;
         rd(4'(8 + i), rv);
         rd(4'(8 + i), rv);
         check(48'(rv), 48'hA5);
         wr(4'(8 + i), 8'h81);
         rd(4'(8 + i), rv);
         check(48'(rv), 48'h24);
      end
      wr(4'h6, 8'h00);
      host.request(1, t);
      check(48'(t), 48'h0);
      check(48'(port_enabled), 48'h0);
      report_and_stop();
   end
endmodule : usb_hub_config_bypass_tb
